/* hw/bcc_pkg.sv */
// ============================================================
// Shared constants for the converter configuration bank
// ============================================================
package bcc_pkg;

	// ============================================================
	// Clock
	// ============================================================
	localparam int CLK_PERIOD_NS = 4;                  // Core clock period

	// ============================================================
	// Register map
	// ============================================================
	localparam logic [7:0] ADDR_SETPOINT     = 8'h00; // output_setpoint
	localparam logic [7:0] ADDR_CTRL_PRI     = 8'h01; // control_primary
	localparam logic [7:0] ADDR_CTRL_SEC     = 8'h02; // control_secondary
	localparam logic [7:0] ADDR_CTRL_TER     = 8'h03; // control_tertiary
	localparam logic [7:0] ADDR_EVENT        = 8'h04; // event_flags
	localparam logic [7:0] UNMAPPED_READ     = 8'h00; // Read value off the map

	// ============================================================
	// Field positions
	// ============================================================
	localparam int CP_SELF_RESET_BIT = 7;              // Self-reset trigger
	localparam int CP_SPREAD_BIT     = 6;              // spread_clock_enable
	localparam int CP_SWITCH_BIT     = 5;              // switching_enable
	localparam int CP_FPWM_BIT       = 4;              // forced_pwm_enable
	localparam int CP_DISCH_BIT      = 3;              // output_discharge_enable
	localparam int CP_HICCUP_BIT     = 2;              // hiccup_enable
	localparam int CP_RAMP_LSB       = 0;              // ramp_speed_select, 2 bits
	localparam int CS_PHASE_BIT      = 4;              // Follower clock phase
	localparam int CS_RANGE_LSB      = 2;              // setpoint_range_select, 2 bits
	localparam int CS_SST_LSB        = 0;              // softstart_time_select, 2 bits

	// ============================================================
	// Reset values
	// ============================================================
	localparam logic [7:0] SETPOINT_RESET = 8'h00;     // Before the pin sample
	localparam logic [7:0] CTRL_PRI_RESET = 8'h28;     // Switching and discharge on
	localparam logic [7:0] CTRL_SEC_RESET = 8'h0A;     // Range 10, soft-start 10
	localparam logic [7:0] CTRL_TER_RESET = 8'h00;     // All options off
	localparam logic [7:0] EVENT_RESET    = 8'h00;     // No events
	localparam logic [7:0] EVENT_MASK     = 8'h3F;     // Implemented event bits

	// ============================================================
	// Setpoint encoding, units of 0.25 mV
	// ============================================================
	localparam logic [12:0] BASE_QMV    = 13'h0640;    // 0.4 V
	localparam logic [12:0] STEP_QMV_R1 = 13'h0005;    // 1.25 mV
	localparam logic [12:0] STEP_QMV_R2 = 13'h000A;    // 2.5 mV
	localparam logic [12:0] STEP_QMV_R3 = 13'h0014;    // 5 mV
	localparam logic [1:0]  RANGE_FINE  = 2'h0;        // 1.25 mV steps
	localparam logic [1:0]  RANGE_MID   = 2'h1;        // 2.5 mV steps

	// ============================================================
	// Timing
	// ============================================================
	localparam int POWERDOWN_NS = 1000;                // Least power-down time
	localparam logic [7:0] POWERDOWN_CYC =
		8'((POWERDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int SYNC_WINDOW_NS = 1000;              // Longest gap in a sync clock
	localparam logic [7:0] SYNC_WINDOW_CYC = 8'(SYNC_WINDOW_NS / CLK_PERIOD_NS);

	// ============================================================
	// Serial target
	// ============================================================
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;  // Arbitrary bus address
	localparam logic [3:0] BITS_PER_BYTE    = 4'h8;   // Bits before acknowledge

	// ============================================================
	// State types
	// ============================================================
	typedef enum logic [1:0] {
		SEQ_SAMPLE,
		SEQ_RUN,
		SEQ_DOWN
	} bcc_seq_t;

	typedef enum logic [2:0] {
		I2C_IDLE,
		I2C_ADDR,
		I2C_ACK_ADDR,
		I2C_WRITE,
		I2C_ACK_WRITE,
		I2C_READ,
		I2C_ACK_READ
	} bcc_i2c_t;

endpackage : bcc_pkg

/* hw/bcc_i2c_target.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Serial bus target: byte engine with acknowledge
// ============================================================
module bcc_i2c_target
	import bcc_pkg::*;
(
	input  wire logic       i_core_clk,
	input  wire logic       i_rst,
	input  wire logic [6:0] i_dev_addr,
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	input  wire logic [7:0] i_rd_data,
	output var  logic       o_sda_out,
	output var  logic       o_sda_oe,
	output var  logic       o_wr_strobe,
	output var  logic       o_wr_first,
	output var  logic [7:0] o_wr_data,
	output var  logic       o_rd_strobe
);

	// All state in one record
	typedef struct packed {
		bcc_i2c_t   state;     // Protocol phase
		logic       scl_q;     // Previous clock level
		logic       sda_q;     // Previous data level
		logic [3:0] bit_cnt;   // Bits in current byte
		logic [7:0] shift;     // Byte shifter
		logic       rw;        // Direction bit
		logic       first;     // Next written byte is the pointer
		logic       sda_oe;    // Pull data low
		logic       wr_strobe; // Byte committed
		logic       wr_first;  // Committed byte is the pointer
		logic [7:0] wr_data;   // Committed byte
		logic       rd_strobe; // Read byte loaded
	} bcc_i2c_state_t;

	localparam bcc_i2c_state_t RESET_STATE = '{
		state: I2C_IDLE, scl_q: 1'b1, sda_q: 1'b1, bit_cnt: 4'h0, shift: 8'h00, rw: 1'b0,
		first: 1'b0, sda_oe: 1'b0, wr_strobe: 1'b0, wr_first: 1'b0, wr_data: 8'h00, rd_strobe: 1'b0};

	bcc_i2c_state_t r_reg;  // Registered state
	bcc_i2c_state_t r_next; // Next state

	logic scl_rise;  // Clock rising
	logic scl_fall;  // Clock falling
	logic start_cnd; // Data falls while clock high
	logic stop_cnd;  // Data rises while clock high

	// ============================================================
	// Next-state logic
	// ============================================================
	always_comb begin
		scl_rise = i_scl & ~r_reg.scl_q;
		scl_fall = ~i_scl & r_reg.scl_q;
		start_cnd = r_reg.scl_q & i_scl & r_reg.sda_q & ~i_sda;
		stop_cnd = r_reg.scl_q & i_scl & ~r_reg.sda_q & i_sda;
		r_next = r_reg;
		r_next.scl_q = i_scl;
		r_next.sda_q = i_sda;
		r_next.wr_strobe = 1'b0;
		r_next.rd_strobe = 1'b0;
		if (start_cnd) begin
			// Start or repeated start
			r_next.state = I2C_ADDR;
			r_next.bit_cnt = 4'h0;
			r_next.sda_oe = 1'b0;
			r_next.first = 1'b1;
		end else if (stop_cnd) begin
			// Stop releases the bus
			r_next.state = I2C_IDLE;
			r_next.sda_oe = 1'b0;
		end else begin
			case (r_reg.state)
				I2C_ADDR, I2C_WRITE: begin
					// Shift in on rising clock
					if (scl_rise) begin
						r_next.shift = {r_reg.shift[6:0], i_sda};
						r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
					end
					if (scl_fall && r_reg.bit_cnt == BITS_PER_BYTE) begin
						if (r_reg.state == I2C_WRITE) begin
							r_next.sda_oe = 1'b1;
							r_next.state = I2C_ACK_WRITE;
						end else if (r_reg.shift[7:1] == i_dev_addr) begin
							r_next.rw = r_reg.shift[0];
							r_next.sda_oe = 1'b1;
							r_next.state = I2C_ACK_ADDR;
						end else begin
							r_next.state = I2C_IDLE;
						end
					end
				end
				I2C_ACK_ADDR, I2C_ACK_READ: begin
					// Controller not-acknowledge ends a read
					if (r_reg.state == I2C_ACK_READ && scl_rise && i_sda) begin
						r_next.state = I2C_IDLE;
					end else if (scl_fall) begin
						r_next.bit_cnt = 4'h0;
						if (r_reg.state == I2C_ACK_READ || r_reg.rw) begin
							r_next.shift = i_rd_data;
							r_next.sda_oe = ~i_rd_data[7];
							r_next.rd_strobe = 1'b1;
							r_next.state = I2C_READ;
						end else begin
							r_next.sda_oe = 1'b0;
							r_next.state = I2C_WRITE;
						end
					end
				end
				I2C_ACK_WRITE: begin
					// Commit on the falling edge ending the acknowledge
					if (scl_fall) begin
						r_next.sda_oe = 1'b0;
						r_next.wr_strobe = 1'b1;
						r_next.wr_first = r_reg.first;
						r_next.wr_data = r_reg.shift;
						r_next.first = 1'b0;
						r_next.bit_cnt = 4'h0;
						r_next.state = I2C_WRITE;
					end
				end
				I2C_READ: begin
					// Shift out on falling clock
					if (scl_fall) begin
						r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
						if (r_reg.bit_cnt == BITS_PER_BYTE - 4'h1) begin
							r_next.sda_oe = 1'b0;
							r_next.state = I2C_ACK_READ;
						end else begin
							r_next.shift = {r_reg.shift[6:0], 1'b0};
							r_next.sda_oe = ~r_reg.shift[6];
						end
					end
				end
				I2C_IDLE: begin
					r_next.sda_oe = 1'b0;
				end
				default: begin
					r_next.state = I2C_IDLE;
					r_next.sda_oe = 1'b0;
				end
			endcase
		end
	end

	// ============================================================
	// State register
	// ============================================================
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			r_reg <= RESET_STATE;
		end else begin
			r_reg <= r_next;
		end
	end

	assign o_sda_out = 1'b0;
	assign o_sda_oe = r_reg.sda_oe;
	assign o_wr_strobe = r_reg.wr_strobe;
	assign o_wr_first = r_reg.wr_first;
	assign o_wr_data = r_reg.wr_data;
	assign o_rd_strobe = r_reg.rd_strobe;

endmodule : bcc_i2c_target
`default_nettype wire

/* hw/bcc_config_regs.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Converter configuration register bank
// ============================================================
module bcc_config_regs
	import bcc_pkg::*;
#(
	parameter logic       SPREAD_DEFAULT = 1'b0,            // Device option
	parameter logic [6:0] DEV_ADDR       = DEV_ADDR_DEFAULT // Bus address
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	output var  logic        o_sda_out,
	output var  logic        o_sda_oe,
	input  wire logic [7:0]  i_setpoint_select_pin,
	input  wire logic        i_mode_sync,
	input  wire logic [5:0]  i_event_pulse,
	output var  logic [7:0]  o_output_setpoint_code,
	output var  logic [12:0] o_setpoint_qmv,
	output var  logic [1:0]  o_setpoint_range_select,
	output var  logic [1:0]  o_ramp_speed_select,
	output var  logic [1:0]  o_softstart_time_select,
	output var  logic        o_spread_clock_enable,
	output var  logic        o_switching_enable,
	output var  logic        o_forced_pwm_enable,
	output var  logic        o_output_discharge_enable,
	output var  logic        o_hiccup_enable,
	output var  logic        o_follower_phase_180,
	output var  logic [7:0]  o_control_tertiary,
	output var  logic        o_power_up,
	output var  logic        o_softstart_start
);

	// ============================================================
	// State record
	// ============================================================
	typedef struct packed {
		bcc_seq_t    seq;         // Power sequence phase
		logic [7:0]  cnt;         // Power-down counter
		logic [7:0]  setpoint;    // output_setpoint
		logic [7:0]  ctrl_pri;    // control_primary, bit 7 never stored
		logic [7:0]  ctrl_sec;    // control_secondary
		logic [7:0]  ctrl_ter;    // control_tertiary
		logic [7:0]  events;      // event_flags
		logic [7:0]  pointer;     // Register pointer
		logic        mode_q;      // Previous mode pin level
		logic [7:0]  sync_cnt;    // Cycles left in the sync window
		logic [12:0] qmv;         // Decoded setpoint
		logic        forced_pwm;  // Effective forced PWM
		logic        switching;   // Effective switching
		logic        power_up;    // Power stage allowed
		logic        ss_start;    // Soft-start trigger
	} bcc_regs_t;

	localparam logic [7:0] PRI_RESET = CTRL_PRI_RESET | {1'b0, SPREAD_DEFAULT, 6'h00};

	localparam bcc_regs_t RESET_STATE = '{
		seq: SEQ_SAMPLE, cnt: 8'h00, setpoint: SETPOINT_RESET, ctrl_pri: PRI_RESET,
		ctrl_sec: CTRL_SEC_RESET, ctrl_ter: CTRL_TER_RESET, events: EVENT_RESET,
		pointer: 8'h00, mode_q: 1'b0, sync_cnt: 8'h00, qmv: BASE_QMV, forced_pwm: 1'b0,
		switching: 1'b0, power_up: 1'b0, ss_start: 1'b0};

	bcc_regs_t   r_reg;     // Registered state
	bcc_regs_t   r_next;    // Next state
	logic [7:0]  rd_data;   // Byte offered to the bus
	logic        wr_strobe; // Committed write
	logic        wr_first;  // Committed byte is the pointer
	logic [7:0]  wr_data;   // Committed byte
	logic        rd_strobe; // Read byte taken
	logic [12:0] step_qmv;  // Step of current range

	// ============================================================
	// Serial target
	// ============================================================
	bcc_i2c_target u_target (
		.i_core_clk  (i_core_clk),
		.i_rst       (i_rst),
		.i_dev_addr  (DEV_ADDR),
		.i_scl       (i_scl),
		.i_sda       (i_sda),
		.i_rd_data   (rd_data),
		.o_sda_out   (o_sda_out),
		.o_sda_oe    (o_sda_oe),
		.o_wr_strobe (wr_strobe),
		.o_wr_first  (wr_first),
		.o_wr_data   (wr_data),
		.o_rd_strobe (rd_strobe)
	);

	// ============================================================
	// Read multiplexer
	// ============================================================
	always_comb begin
		case (r_reg.pointer)
			ADDR_SETPOINT: rd_data = r_reg.setpoint;
			ADDR_CTRL_PRI: rd_data = {1'b0, r_reg.ctrl_pri[6:0]};
			ADDR_CTRL_SEC: rd_data = r_reg.ctrl_sec;
			ADDR_CTRL_TER: rd_data = r_reg.ctrl_ter;
			ADDR_EVENT:    rd_data = r_reg.events;
			default:       rd_data = UNMAPPED_READ;
		endcase
	end

	// ============================================================
	// Next-state logic
	// ============================================================
	always_comb begin
		r_next = r_reg;
		r_next.ss_start = 1'b0;
		r_next.mode_q = i_mode_sync;
		// Sync clock seen while edges keep arriving
		if (i_mode_sync != r_reg.mode_q) begin
			r_next.sync_cnt = SYNC_WINDOW_CYC;
		end else if (r_reg.sync_cnt != 8'h00) begin
			r_next.sync_cnt = r_reg.sync_cnt - 8'h01;
		end
		// Reads advance the pointer; reading events clears them
		if (rd_strobe) begin
			r_next.pointer = r_reg.pointer + 8'h01;
			if (r_reg.pointer == ADDR_EVENT) begin
				r_next.events = EVENT_RESET;
			end
		end
		// New events win over a clear in the same cycle
		r_next.events = (r_next.events | {2'b00, i_event_pulse}) & EVENT_MASK;
		case (r_reg.seq)
			SEQ_SAMPLE: begin
				// Pins sampled after reset release
				r_next.setpoint = i_setpoint_select_pin;
				r_next.power_up = 1'b1;
				r_next.ss_start = 1'b1;
				r_next.seq = SEQ_RUN;
			end
			SEQ_RUN: begin
				if (wr_strobe && wr_first) begin
					// First byte sets the pointer
					r_next.pointer = wr_data;
				end else if (wr_strobe) begin
					r_next.pointer = r_reg.pointer + 8'h01;
					case (r_reg.pointer)
						ADDR_SETPOINT: r_next.setpoint = wr_data;
						ADDR_CTRL_PRI: begin
							if (wr_data[CP_SELF_RESET_BIT]) begin
								// Self-reset: defaults, then power down
								r_next = RESET_STATE;
								r_next.mode_q = i_mode_sync;
								r_next.events = {2'b00, i_event_pulse} & EVENT_MASK;
								r_next.seq = SEQ_DOWN;
								r_next.cnt = POWERDOWN_CYC;
							end else begin
								r_next.ctrl_pri = {1'b0, wr_data[6:0]};
							end
						end
						ADDR_CTRL_SEC: r_next.ctrl_sec = wr_data;
						ADDR_CTRL_TER: r_next.ctrl_ter = wr_data;
						default: r_next.pointer = r_reg.pointer + 8'h01;
					endcase
				end
			end
			SEQ_DOWN: begin
				// Power stage held off, bus writes ignored
				r_next.power_up = 1'b0;
				r_next.cnt = r_reg.cnt - 8'h01;
				if (r_reg.cnt == 8'h01) begin
					r_next.seq = SEQ_SAMPLE;
				end
			end
			default: begin
				r_next.seq = SEQ_SAMPLE;
			end
		endcase
		// Decoded outputs registered from the next register values
		r_next.forced_pwm = r_next.ctrl_pri[CP_FPWM_BIT] | i_mode_sync | (r_next.sync_cnt != 8'h00);
		r_next.switching = r_next.ctrl_pri[CP_SWITCH_BIT] & r_next.power_up;
		// Step of the range being loaded
		case (r_next.ctrl_sec[CS_RANGE_LSB +: 2])
			RANGE_FINE: step_qmv = STEP_QMV_R1;
			RANGE_MID:  step_qmv = STEP_QMV_R2;
			default:    step_qmv = STEP_QMV_R3;
		endcase
		r_next.qmv = BASE_QMV + 13'({5'h00, r_next.setpoint} * step_qmv);
	end

	// ============================================================
	// State register
	// ============================================================
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			r_reg <= RESET_STATE;
		end else begin
			r_reg <= r_next;
		end
	end

	// ============================================================
	// Outputs, all from the state record
	// ============================================================
	assign o_output_setpoint_code = r_reg.setpoint;
	assign o_setpoint_qmv = r_reg.qmv;
	assign o_setpoint_range_select = r_reg.ctrl_sec[CS_RANGE_LSB +: 2];
	assign o_ramp_speed_select = r_reg.ctrl_pri[CP_RAMP_LSB +: 2];
	assign o_softstart_time_select = r_reg.ctrl_sec[CS_SST_LSB +: 2];
	assign o_spread_clock_enable = r_reg.ctrl_pri[CP_SPREAD_BIT];
	assign o_switching_enable = r_reg.switching;
	assign o_forced_pwm_enable = r_reg.forced_pwm;
	assign o_output_discharge_enable = r_reg.ctrl_pri[CP_DISCH_BIT];
	assign o_hiccup_enable = r_reg.ctrl_pri[CP_HICCUP_BIT];
	assign o_follower_phase_180 = r_reg.ctrl_sec[CS_PHASE_BIT];
	assign o_control_tertiary = r_reg.ctrl_ter;
	assign o_power_up = r_reg.power_up;
	assign o_softstart_start = r_reg.ss_start;

endmodule : bcc_config_regs
`default_nettype wire

/* verification/bcc_config_regs_sva.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Port checker for the configuration bank
// ============================================================
module bcc_config_regs_sva (
	input wire logic        i_core_clk,
	input wire logic        i_rst,
	input wire logic        i_mode_sync,
	input wire logic [7:0]  o_output_setpoint_code,
	input wire logic [12:0] o_setpoint_qmv,
	input wire logic [1:0]  o_setpoint_range_select,
	input wire logic [1:0]  o_ramp_speed_select,
	input wire logic [1:0]  o_softstart_time_select,
	input wire logic        o_switching_enable,
	input wire logic        o_forced_pwm_enable,
	input wire logic        o_output_discharge_enable,
	input wire logic        o_hiccup_enable,
	input wire logic        o_follower_phase_180,
	input wire logic        o_power_up,
	input wire logic        o_softstart_start
);
	typedef struct packed {logic armed; logic [8:0] cnt;} bcc_pd_t; // Power-down tracker
	bcc_pd_t     pd_reg;  // Cycles spent powered down
	bcc_pd_t     pd_next; // Next tracker value
	logic [12:0] step;    // Step in 0.25 mV units
	assign step = (o_setpoint_range_select == 2'h0) ? 13'h0005 :
		(o_setpoint_range_select == 2'h1) ? 13'h000A : 13'h0014;
	// Count low cycles; armed once power was up after reset
	always_comb begin
		pd_next = pd_reg;
		if (o_power_up) begin
			pd_next = '{armed: 1'b1, cnt: 9'h000};
		end else if (pd_reg.cnt != 9'h1FF) begin
			pd_next.cnt = pd_reg.cnt + 9'h001;
		end
	end
	// Tracker register
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pd_reg <= '0;
		end else begin
			pd_reg <= pd_next;
		end
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	a_setpoint_scale: assert property (
		$stable(o_output_setpoint_code) && $stable(o_setpoint_range_select) |->
		o_setpoint_qmv == 13'h0640 + {5'h00, o_output_setpoint_code} * step) else $error("setpoint scale wrong");
	a_mode_pin_pwm: assert property (
		i_mode_sync |=> o_forced_pwm_enable) else $error("mode pin did not force pwm");
	a_sync_clock_pwm: assert property (
		$changed(i_mode_sync) |=> o_forced_pwm_enable [*8]) else $error("sync clock did not force pwm");
	a_softstart_once: assert property (
		o_softstart_start |=> !o_softstart_start) else $error("softstart pulse too long");
	a_powerup_softstart: assert property (
		$rose(o_power_up) |-> o_softstart_start) else $error("power up without softstart");
	a_switch_needs_power: assert property (
		o_switching_enable |-> o_power_up) else $error("switching while powered down");
	a_powerdown_length: assert property (
		$rose(o_power_up) && pd_reg.armed |-> pd_reg.cnt >= 9'h0F9 && pd_reg.cnt <= 9'h0FE)
		else $error("power-down time wrong");
	a_powerdown_bound: assert property (
		pd_reg.armed && !o_power_up |-> pd_reg.cnt < 9'h100) else $error("power-down never ends");
	a_reset_fields: assert property (
		$fell(i_rst) |-> o_output_discharge_enable && !o_hiccup_enable && !o_follower_phase_180 &&
		o_ramp_speed_select == 2'h0 && o_setpoint_range_select == 2'h2 && o_softstart_time_select == 2'h2)
		else $error("field reset values wrong");
endmodule : bcc_config_regs_sva
bind bcc_config_regs bcc_config_regs_sva chk_u (.i_core_clk, .i_rst, .i_mode_sync, .o_output_setpoint_code,
	.o_setpoint_qmv, .o_setpoint_range_select, .o_ramp_speed_select, .o_softstart_time_select,
	.o_switching_enable, .o_forced_pwm_enable, .o_output_discharge_enable, .o_hiccup_enable,
	.o_follower_phase_180, .o_power_up, .o_softstart_start);
`default_nettype wire

/* verification/bcc_i2c_ctl.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Host-side serial bus controller model
// ============================================================
module bcc_i2c_ctl (
	input  wire logic i_core_clk, // Paces the bus levels
	input  wire logic i_sda,      // Resolved data wire
	output var  logic o_scl,      // Bus clock
	output var  logic o_sda       // One releases the wire
);
	int         half = 3;     // Core cycles per clock high level; the low level lasts one more
	logic [6:0] dev  = 7'h2A; // Target address, arbitrary
	// Idle bus: both lines released high
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask : cyc
	// One bit: data set in the low phase, sampled at end of high
	task automatic bit_io(input logic b, output logic r);
		o_sda <= b;
		cyc(half);
		o_scl <= 1'b1;
		cyc(half);
		r = i_sda;
		o_scl <= 1'b0;
		cyc(1);
	endtask : bit_io
	// Eight bits MSB first, then the acknowledge slot
	task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(a, ack);
	endtask : byte_io
	// Start or repeated start: data falls with clock high
	task automatic start();
		o_sda <= 1'b1;
		cyc(half);
		o_scl <= 1'b1;
		cyc(half);
		o_sda <= 1'b0;
		cyc(half);
		o_scl <= 1'b0;
		cyc(1);
	endtask : start
	// Stop: data rises with clock high
	task automatic stop();
		o_sda <= 1'b0;
		cyc(half);
		o_scl <= 1'b1;
		cyc(half);
		o_sda <= 1'b1;
		cyc(half);
	endtask : stop
	// Start, address with write, register pointer
	task automatic head(input logic [7:0] a, output logic ok);
		logic [7:0] q;
		logic       k0;
		logic       k1;
		start();
		byte_io({dev, 1'b0}, 1'b1, q, k0);
		byte_io(a, 1'b1, q, k1);
		ok = ~(k0 | k1);
	endtask : head
	// Single register write
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic       k;
		head(a, ok);
		byte_io(d, 1'b1, q, k);
		stop();
		ok = ok & ~k;
	endtask : wr
	// Single register read, ended by not-acknowledge
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic       k;
		logic       n;
		head(a, ok);
		start();
		byte_io({dev, 1'b1}, 1'b1, q, k);
		byte_io(8'hFF, 1'b1, d, n);
		stop();
		ok = ok & ~k;
	endtask : rd
endmodule : bcc_i2c_ctl
`default_nettype wire

/* verification/bcc_config_regs_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Self-checking bench for the configuration bank
// ============================================================
module bcc_config_regs_tb_top import bcc_pkg::*; ();
	logic        clk, rst, scl, sda_c, mode, sda_out, oe, ok; // Stimulus and bus
	logic        spread, sw, fpwm, disch, hic, ph, pwr, ss;    // Control outputs
	logic [7:0]  pin, code, tert, d, rv;                       // Bytes
	logic [5:0]  evt;                                          // Event inputs
	logic [12:0] qmv;                                          // Setpoint output
	logic [1:0]  rng, ramp, sst;                               // Select fields
	logic [7:0]  m [0:4];                                      // Expected registers
	int          bad_count = 0, checked = 0, ra, n;            // Counters
	wire  logic  sda_w;                                        // Pulled-up data wire
	assign sda_w = sda_c & ~oe;
	bcc_config_regs dut_u (.i_core_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda_w), .o_sda_out(sda_out),
		.o_sda_oe(oe), .i_setpoint_select_pin(pin), .i_mode_sync(mode), .i_event_pulse(evt),
		.o_output_setpoint_code(code), .o_setpoint_qmv(qmv), .o_setpoint_range_select(rng),
		.o_ramp_speed_select(ramp), .o_softstart_time_select(sst), .o_spread_clock_enable(spread),
		.o_switching_enable(sw), .o_forced_pwm_enable(fpwm), .o_output_discharge_enable(disch),
		.o_hiccup_enable(hic), .o_follower_phase_180(ph), .o_control_tertiary(tert), .o_power_up(pwr),
		.o_softstart_start(ss));
	bcc_i2c_ctl ctl_u (.i_core_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda(sda_c));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Compare and count
	task automatic chk(input logic [12:0] g, input logic [12:0] e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// Expected setpoint in 0.25 mV units
	function automatic logic [12:0] qmv_of(input logic [7:0] c, input logic [1:0] r);
		return 13'h0640 + {5'h00, c} * ((r == 2'h0) ? 13'h0005 : (r == 2'h1) ? 13'h000A : 13'h0014);
	endfunction : qmv_of
	task automatic end_sim();
		if (bad_count == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_sim
	task automatic wr_chk(input logic [7:0] a, input logic [7:0] v);
		ctl_u.wr(a, v, ok);
		chk({12'h000, ok}, 13'h0001);
	endtask : wr_chk
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		ctl_u.rd(a, d, ok);
		chk({12'h000, ok}, 13'h0001);
		chk({5'h00, d}, {5'h00, e});
	endtask : rd_chk
	// Outputs against the expected registers
	task automatic check_ports();
		chk({5'h00, code}, {5'h00, m[0]});
		chk(qmv, qmv_of(m[0], m[2][3:2]));
		chk({1'b0, spread, sw, fpwm, disch, hic, ramp, ph, rng, sst}, {1'b0, m[1][6:0], m[2][4:0]});
		chk({5'h00, tert}, {5'h00, m[3]});
		chk({12'h000, sda_out}, 13'h0000);
	endtask : check_ports
	// Main sequence
	initial begin
		rst = 1'b1;
		mode = 1'b0;
		evt = 6'h00;
		void'($urandom(55782));
		pin = 8'($urandom);
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		m = '{pin, 8'h28, 8'h0A, 8'h00, 8'h00};
		repeat (4) @(posedge clk);
		check_ports();
		for (int k = 0; k < 5; k++) rd_chk(8'(k), m[k]);
		// Random writes at prompt and slow bus rates
		repeat (16) begin
			ctl_u.half = 3 + 6 * int'($urandom_range(1));
			ra = int'($urandom_range(3));
			rv = 8'($urandom);
			if (ra == 1) rv[7] = 1'b0;   // No self-reset here
			if (ra == 2) rv[7:5] = 3'h0;
			m[ra] = rv;
			wr_chk(ra[7:0], rv);
			rd_chk(ra[7:0], m[ra]);
			check_ports();
		end
		ctl_u.half = 3;
		for (int k = 0; k < 4; k++) begin
			m[1] = 8'h28 | 8'(k);
			wr_chk(8'h01, m[1]);
			check_ports();
		end
		for (int k = 0; k < 32; k++) begin
			m[2] = 8'(k);
			wr_chk(8'h02, m[2]);
			m[0] = 8'($urandom);
			wr_chk(8'h00, m[0]);
			check_ports();
		end
		wr_chk(8'h05, 8'hA5);
		check_ports();
		rd_chk(8'h05, 8'h00);
		rd_chk(8'hFF, 8'h00);
		evt <= 6'h2D;
		@(posedge clk);
		evt <= 6'h00;
		rd_chk(ADDR_EVENT, 8'h2D);
		rd_chk(ADDR_EVENT, 8'h00);
		mode <= 1'b1;
		repeat (3) @(posedge clk);
		chk({12'h000, fpwm}, 13'h0001);
		mode <= 1'b0;
		repeat (300) @(posedge clk);
		chk({12'h000, fpwm}, {12'h000, m[1][4]});
		pin <= 8'h93;
		wr_chk(ADDR_CTRL_PRI, 8'hA8);
		chk({12'h000, pwr}, 13'h0000);
		n = 0;
		while (pwr !== 1'b1 && n < 600) begin
			@(posedge clk);
			n++;
		end
		if (n == 600) begin
			$display("BAD t=%0t power-up timeout", $time);
			bad_count++;
		end
		m = '{8'h93, 8'h28, 8'h0A, 8'h00, 8'h00};
		repeat (2) @(posedge clk);
		check_ports();
		rd_chk(ADDR_CTRL_PRI, 8'h28);
		end_sim();
	end
endmodule : bcc_config_regs_tb_top
`default_nettype wire
